/* File: src/encl_chk.sv */
// Purpose: legality and permission checks for enclave instruction families
// Assumes: all inputs synchronous to clk; one request per cycle at most
// Notes: results appear one cycle after the request; done is a registered pulse, fault and addr_64 hold
`timescale 1ns/1ps
`default_nettype none
module encl_chk #(
  parameter bit GEN1_SUPPORT = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // processor mode
  input wire logic prot_mode,
  input wire logic system_mgmt_mode,
  input wire logic virtual_8086_mode,
  input wire logic paging_enable,
  input wire logic long_mode,
  input wire logic cs_64bit,
  input wire logic [1:0] privilege_level,
  input wire logic guest_mode,
  // enclave instruction request
  input wire logic req,
  input wire logic user_enclave_op,
  input wire logic [5:0] leaf,
  input wire logic opsize_prefix,
  input wire logic page_cache_access_ok,
  // segment state
  input wire logic ds_usable,
  input wire logic ds_expand_up,
  input wire logic [63:0] ds_base,
  input wire logic [31:0] ds_limit,
  input wire logic [7:0] ds_rights,
  input wire logic other_bases_zero,
  input wire logic [63:0] cur_a_base,
  input wire logic [31:0] cur_a_limit,
  input wire logic [23:0] cur_a_attr,
  input wire logic [63:0] cur_b_base,
  input wire logic [31:0] cur_b_limit,
  input wire logic [23:0] cur_b_attr,
  // enclave structures
  input wire logic [63:0] enclave_base,
  input wire logic enclave_64bit_attr,
  input wire logic [63:0] tls_a_base_offset,
  input wire logic [63:0] tls_b_base_offset,
  input wire logic [31:0] tls_a_limit,
  input wire logic [31:0] tls_b_limit,
  input wire logic [63:0] frame_a_base,
  input wire logic [63:0] frame_b_base,
  // in-enclave events
  input wire logic seg_modify,
  input wire logic write_tls_base_a,
  input wire logic write_tls_base_b,
  input wire logic [63:0] tls_wdata,
  input wire logic async_enclave_exit,
  // check result
  output logic done,
  output encl_chk_pkg::fault_t fault,
  output logic addr_64,
  output logic ad_set,
  output logic in_enclave,
  // tls segment load
  output logic tls_load,
  output logic [63:0] tls_a_base_o,
  output logic [31:0] tls_a_limit_o,
  output logic [23:0] tls_a_attr_o,
  output logic [63:0] tls_b_base_o,
  output logic [31:0] tls_b_limit_o,
  output logic [23:0] tls_b_attr_o,
  // state save frame write
  output logic frame_wr
);
  typedef struct packed {
    logic [31:0] fc;
    logic exit_en;
    logic [63:0] bitmap;
    logic [31:0] key;
    logic ack;
    logic [31:0] rdata;
    logic in_enc;
    logic enc64;
    logic [63:0] sv_a_base;
    logic [31:0] sv_a_lim;
    logic [23:0] sv_a_attr;
    logic [63:0] sv_b_base;
    logic [31:0] sv_b_lim;
    logic [23:0] sv_b_attr;
    logic [63:0] a_base;
    logic [31:0] a_lim;
    logic [23:0] a_attr;
    logic [63:0] b_base;
    logic [31:0] b_lim;
    logic [23:0] b_attr;
    logic tls_load;
    logic frame_wr;
    logic done;
    encl_chk_pkg::fault_t fault;
    encl_chk_pkg::fault_t last;
    logic addr64;
    logic ad_set;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    be_merge = r;
  endfunction : be_merge

  // range b..b+l inside data segment; 65-bit sums avoid wraparound escapes
  function automatic logic in_ds(input logic [63:0] b, input logic [31:0] l);
    in_ds = (b >= ds_base) && (({1'b0, b} + {33'h0, l}) <= ({1'b0, ds_base} + {33'h0, ds_limit}));
  endfunction : in_ds

  logic encl_on;
  logic key_wr_ok;
  logic bus_req;
  assign encl_on = q.fc[encl_chk_pkg::FC_ENCL_EN] & q.fc[encl_chk_pkg::FC_LOCK];
  assign key_wr_ok = GEN1_SUPPORT & q.fc[encl_chk_pkg::FC_KEY_WR] & q.fc[encl_chk_pkg::FC_LOCK];
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~q.ack;

  always_comb begin
    logic [63:0] na;
    logic [63:0] nb;
    logic is_entry;
    logic is_resume;
    logic is_exit;
    encl_chk_pkg::fault_t f;
    d = q;
    na = 64'h0;
    nb = 64'h0;
    f = encl_chk_pkg::FLT_NONE;
    d.done = 1'b0;
    d.tls_load = 1'b0;
    d.frame_wr = 1'b0;
    d.ad_set = 1'b0;
    d.ack = bus_req & ~q.ack;
    is_entry = user_enclave_op & (leaf == encl_chk_pkg::LEAF_ENTRY);
    is_resume = user_enclave_op & (leaf == encl_chk_pkg::LEAF_RESUME);
    is_exit = user_enclave_op & (leaf == encl_chk_pkg::LEAF_EXIT);
    // register reads sampled on the first cycle, writes on the answer edge
    if (bus_req & ~q.ack & avs_read) begin
      case (avs_address)
        encl_chk_pkg::OFS_FEAT_CTRL: d.rdata = q.fc;
        encl_chk_pkg::OFS_EXIT_CTRL: d.rdata = {31'h0, q.exit_en};
        encl_chk_pkg::OFS_BITMAP_LO: d.rdata = q.bitmap[31:0];
        encl_chk_pkg::OFS_BITMAP_HI: d.rdata = q.bitmap[63:32];
        encl_chk_pkg::OFS_STATUS: d.rdata = {26'h0, q.last, key_wr_ok, q.enc64, q.in_enc, encl_on};
        encl_chk_pkg::OFS_KEY_HASH: d.rdata = GEN1_SUPPORT ? q.key : 32'h0;
        encl_chk_pkg::OFS_CAPS: d.rdata = {31'h0, GEN1_SUPPORT};
        default: d.rdata = 32'h0;
      endcase
    end
    if (q.ack & avs_write) begin
      case (avs_address)
        encl_chk_pkg::OFS_FEAT_CTRL: begin
          // once locked, feature control is frozen until reset
          if (!q.fc[encl_chk_pkg::FC_LOCK]) begin
            d.fc = be_merge(q.fc, avs_writedata, avs_byteenable) & encl_chk_pkg::FC_WR_MASK;
          end
        end
        encl_chk_pkg::OFS_EXIT_CTRL: begin
          if (avs_byteenable[0]) begin
            d.exit_en = avs_writedata[0];
          end
        end
        encl_chk_pkg::OFS_BITMAP_LO: d.bitmap[31:0] = be_merge(q.bitmap[31:0], avs_writedata, avs_byteenable);
        encl_chk_pkg::OFS_BITMAP_HI: d.bitmap[63:32] = be_merge(q.bitmap[63:32], avs_writedata, avs_byteenable);
        encl_chk_pkg::OFS_KEY_HASH: begin
          if (key_wr_ok) begin
            d.key = be_merge(q.key, avs_writedata, avs_byteenable);
          end
        end
        default: d.rdata = q.rdata;
      endcase
    end
    // checks, in priority order; no tls or enclave state moves unless all pass
    if (req) begin
      if (!prot_mode || system_mgmt_mode || virtual_8086_mode) begin
        f = encl_chk_pkg::FLT_UD;
      end else if (!encl_on) begin
        f = encl_chk_pkg::FLT_UD;
      end else if (opsize_prefix) begin
        f = encl_chk_pkg::FLT_UD;
      end else if (!paging_enable && (user_enclave_op || (leaf != encl_chk_pkg::LEAF_DBG_RD
                   && leaf != encl_chk_pkg::LEAF_DBG_WR))) begin
        f = encl_chk_pkg::FLT_UD;
      end else if (!ds_usable || !ds_expand_up) begin
        f = encl_chk_pkg::FLT_GP;
      end else if (!user_enclave_op) begin
        if (privilege_level != encl_chk_pkg::PL_SUPERVISOR) begin
          f = encl_chk_pkg::FLT_GP;
        end else if (guest_mode && q.exit_en && q.bitmap[leaf]) begin
          f = encl_chk_pkg::FLT_VMEXIT;
        end
      end else if (is_entry || is_resume) begin
        // user leaves ignore guest_mode entirely
        na = enclave_base + tls_a_base_offset;
        nb = enclave_base + tls_b_base_offset;
        if (q.in_enc || !other_bases_zero) begin
          f = encl_chk_pkg::FLT_GP;
        end else if (cs_64bit != enclave_64bit_attr || privilege_level != encl_chk_pkg::PL_USER) begin
          f = encl_chk_pkg::FLT_GP;
        end else if (!in_ds(na, tls_a_limit) || !in_ds(nb, tls_b_limit)) begin
          f = encl_chk_pkg::FLT_GP;
        end
      end else if (is_exit && !q.in_enc) begin
        f = encl_chk_pkg::FLT_GP;
      end
      d.done = 1'b1;
      d.fault = f;
      d.last = f;
      d.addr64 = long_mode & cs_64bit;
      d.ad_set = page_cache_access_ok;
      if (f == encl_chk_pkg::FLT_NONE && (is_entry || is_resume)) begin
        d.sv_a_base = cur_a_base;
        d.sv_a_lim = cur_a_limit;
        d.sv_a_attr = cur_a_attr;
        d.sv_b_base = cur_b_base;
        d.sv_b_lim = cur_b_limit;
        d.sv_b_attr = cur_b_attr;
        d.a_base = (is_resume && enclave_64bit_attr) ? frame_a_base : na;
        d.b_base = (is_resume && enclave_64bit_attr) ? frame_b_base : nb;
        d.a_lim = tls_a_limit;
        d.b_lim = tls_b_limit;
        d.a_attr = {encl_chk_pkg::ENTRY_SELECTOR, ds_rights};
        d.b_attr = {encl_chk_pkg::ENTRY_SELECTOR, ds_rights};
        d.in_enc = 1'b1;
        d.enc64 = enclave_64bit_attr;
        d.tls_load = 1'b1;
      end else if (f == encl_chk_pkg::FLT_NONE && is_exit) begin
        d.a_base = q.sv_a_base;
        d.a_lim = q.sv_a_lim;
        d.a_attr = q.sv_a_attr;
        d.b_base = q.sv_b_base;
        d.b_lim = q.sv_b_lim;
        d.b_attr = q.sv_b_attr;
        d.in_enc = 1'b0;
        d.tls_load = 1'b1;
      end
    end else if (q.in_enc && async_enclave_exit) begin
      // outputs already show restored bases at frame_wr; frame takes the cycle before
      d.frame_wr = 1'b1;
      d.a_base = q.sv_a_base;
      d.a_lim = q.sv_a_lim;
      d.a_attr = q.sv_a_attr;
      d.b_base = q.sv_b_base;
      d.b_lim = q.sv_b_lim;
      d.b_attr = q.sv_b_attr;
      d.in_enc = 1'b0;
      d.tls_load = 1'b1;
    end else if (q.in_enc && seg_modify) begin
      d.done = 1'b1;
      d.fault = encl_chk_pkg::FLT_UD;
      d.last = encl_chk_pkg::FLT_UD;
    end else if (q.in_enc && (write_tls_base_a || write_tls_base_b)) begin
      d.done = 1'b1;
      d.fault = q.enc64 ? encl_chk_pkg::FLT_NONE : encl_chk_pkg::FLT_UD;
      d.last = d.fault;
      if (q.enc64 && write_tls_base_a) begin
        d.a_base = tls_wdata;
      end
      if (q.enc64 && write_tls_base_b) begin
        d.b_base = tls_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.fc <= encl_chk_pkg::FC_RESET;
      q.bitmap <= encl_chk_pkg::BITMAP_RESET;
      q.key <= encl_chk_pkg::KEY_RESET;
    end else begin
      q <= d;
    end
  end
  assign avs_readdata = q.rdata;
  assign done = q.done;
  assign fault = q.fault;
  assign addr_64 = q.addr64;
  assign ad_set = q.ad_set;
  assign in_enclave = q.in_enc;
  assign tls_load = q.tls_load;
  assign tls_a_base_o = q.a_base;
  assign tls_a_limit_o = q.a_lim;
  assign tls_a_attr_o = q.a_attr;
  assign tls_b_base_o = q.b_base;
  assign tls_b_limit_o = q.b_lim;
  assign tls_b_attr_o = q.b_attr;
  assign frame_wr = q.frame_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_mode_gate: assert property (req && (!prot_mode || system_mgmt_mode) |=> done && fault == encl_chk_pkg::FLT_UD)
    else $error("illegal mode not refused");
  a_paging_need: assert property (req && prot_mode && !system_mgmt_mode && !virtual_8086_mode
    && user_enclave_op && !paging_enable |=> fault == encl_chk_pkg::FLT_UD)
    else $error("paging off not refused");
  a_enable_lock: assert property (req && !encl_on |=> fault != encl_chk_pkg::FLT_NONE)
    else $error("leaf ran while disabled");
  a_opsize_ud: assert property (req && encl_on && prot_mode && !system_mgmt_mode && !virtual_8086_mode
    && opsize_prefix |=> fault == encl_chk_pkg::FLT_UD)
    else $error("operand prefix not refused");
  a_key_guard: assert property (!key_wr_ok |=> $stable(q.key))
    else $error("key hash changed while protected");
  a_ds_gp: assert property (req && fault_seen_ds() |=> fault == encl_chk_pkg::FLT_GP)
    else $error("bad data segment not refused");
  a_bitmap_exit: assert property (req && encl_on && prot_mode && !system_mgmt_mode && !virtual_8086_mode
    && paging_enable && !opsize_prefix && ds_usable && ds_expand_up && !user_enclave_op
    && privilege_level == 2'h0 && guest_mode && !q.exit_en |=> fault == encl_chk_pkg::FLT_NONE)
    else $error("supervisor leaf exited with control clear");
  a_fault_keeps: assert property (done && fault != encl_chk_pkg::FLT_NONE |-> !tls_load)
    else $error("state moved on a faulting leaf");
  a_exit_restore: assert property (tls_load && !in_enclave |-> tls_a_base_o == q.sv_a_base
    && tls_b_limit_o == q.sv_b_lim)
    else $error("exit did not restore saved tls");
  a_seg_mod_ud: assert property (in_enclave && !req && !async_enclave_exit && seg_modify
    |=> done ##0 fault == encl_chk_pkg::FLT_UD)
    else $error("segment change inside enclave allowed");
  c_entry_ok: cover property (done && tls_load && in_enclave);
  c_vm_exit: cover property (done && fault == encl_chk_pkg::FLT_VMEXIT);
  c_async_out: cover property (frame_wr);
  c_reg_write: cover property (avs_write && !avs_waitrequest);
  function automatic logic fault_seen_ds();
    fault_seen_ds = prot_mode && !system_mgmt_mode && !virtual_8086_mode && encl_on && !opsize_prefix
      && paging_enable && !(ds_usable && ds_expand_up);
  endfunction : fault_seen_ds
endmodule : encl_chk
`default_nettype wire

/* File: src/encl_chk_pkg.sv */
// Purpose: constants and types for the enclave instruction permission checker
// Assumes: 32-bit Avalon-MM register window, byte addressed
// Notes: leaf numbers are plain defaults
package encl_chk_pkg;
  typedef enum logic [1:0] {FLT_NONE, FLT_UD, FLT_GP, FLT_VMEXIT} fault_t;
  // register byte offsets
  localparam logic [4:0] OFS_FEAT_CTRL = 5'h00;
  localparam logic [4:0] OFS_EXIT_CTRL = 5'h04;
  localparam logic [4:0] OFS_BITMAP_LO = 5'h08;
  localparam logic [4:0] OFS_BITMAP_HI = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_KEY_HASH = 5'h14;
  localparam logic [4:0] OFS_CAPS = 5'h18;
  // feature control fields
  localparam int FC_LOCK = 0;
  localparam int FC_KEY_WR = 17;
  localparam int FC_ENCL_EN = 18;
  localparam logic [31:0] FC_WR_MASK = 32'h0006_0001;
  localparam int CAPS_GEN1 = 0;
  // reset values
  localparam logic [31:0] FC_RESET = 32'h0000_0000;
  localparam logic [63:0] BITMAP_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] KEY_RESET = 32'h0000_0000;
  // leaf numbers, privilege levels and entry selector
  localparam logic [5:0] LEAF_ENTRY = 6'h02;
  localparam logic [5:0] LEAF_RESUME = 6'h03;
  localparam logic [5:0] LEAF_EXIT = 6'h04;
  localparam logic [5:0] LEAF_DBG_RD = 6'h04;
  localparam logic [5:0] LEAF_DBG_WR = 6'h05;
  localparam logic [1:0] PL_SUPERVISOR = 2'h0;
  localparam logic [1:0] PL_USER = 2'h3;
  localparam logic [15:0] ENTRY_SELECTOR = 16'h000B;
endpackage : encl_chk_pkg

/* File: tb/enclave_instr_permission_check_tb.sv */
// Purpose: self-checking bench for the enclave instruction permission checker
// Assumes: one request per call, results registered one cycle after it
// Notes: registers reached over avalon-mm; every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module enclave_instr_permission_check_tb;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, prot_mode, system_mgmt_mode, virtual_8086_mode;
  logic paging_enable, long_mode, cs_64bit, guest_mode, req, user_enclave_op, opsize_prefix, page_cache_access_ok;
  logic ds_usable, ds_expand_up, other_bases_zero, enclave_64bit_attr, seg_modify, write_tls_base_a;
  logic write_tls_base_b, async_enclave_exit, done, addr_64, ad_set, in_enclave, tls_load, frame_wr;
  logic [1:0] privilege_level;
  logic [3:0] avs_byteenable;
  logic [4:0] avs_address;
  logic [5:0] leaf;
  logic [7:0] ds_rights;
  logic [23:0] cur_a_attr, cur_b_attr, tls_a_attr_o, tls_b_attr_o;
  logic [31:0] avs_writedata, avs_readdata, ds_limit, cur_a_limit, cur_b_limit, q;
  logic [31:0] tls_a_limit, tls_b_limit, tls_a_limit_o, tls_b_limit_o;
  logic [63:0] ds_base, cur_a_base, cur_b_base, enclave_base, tls_a_base_offset, tls_b_base_offset;
  logic [63:0] frame_a_base, frame_b_base, tls_wdata, tls_a_base_o, tls_b_base_o;
  encl_chk_pkg::fault_t fault;
  int err_count, num_checks;

  encl_chk dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .prot_mode(prot_mode), .system_mgmt_mode(system_mgmt_mode),
    .virtual_8086_mode(virtual_8086_mode), .paging_enable(paging_enable), .long_mode(long_mode),
    .cs_64bit(cs_64bit), .privilege_level(privilege_level), .guest_mode(guest_mode), .req(req),
    .user_enclave_op(user_enclave_op), .leaf(leaf), .opsize_prefix(opsize_prefix),
    .page_cache_access_ok(page_cache_access_ok), .ds_usable(ds_usable), .ds_expand_up(ds_expand_up),
    .ds_base(ds_base), .ds_limit(ds_limit), .ds_rights(ds_rights), .other_bases_zero(other_bases_zero),
    .cur_a_base(cur_a_base), .cur_a_limit(cur_a_limit), .cur_a_attr(cur_a_attr), .cur_b_base(cur_b_base),
    .cur_b_limit(cur_b_limit), .cur_b_attr(cur_b_attr), .enclave_base(enclave_base),
    .enclave_64bit_attr(enclave_64bit_attr), .tls_a_base_offset(tls_a_base_offset),
    .tls_b_base_offset(tls_b_base_offset), .tls_a_limit(tls_a_limit), .tls_b_limit(tls_b_limit),
    .frame_a_base(frame_a_base), .frame_b_base(frame_b_base), .seg_modify(seg_modify),
    .write_tls_base_a(write_tls_base_a), .write_tls_base_b(write_tls_base_b), .tls_wdata(tls_wdata),
    .async_enclave_exit(async_enclave_exit), .done(done), .fault(fault), .addr_64(addr_64), .ad_set(ad_set),
    .in_enclave(in_enclave), .tls_load(tls_load), .tls_a_base_o(tls_a_base_o), .tls_a_limit_o(tls_a_limit_o),
    .tls_a_attr_o(tls_a_attr_o), .tls_b_base_o(tls_b_base_o), .tls_b_limit_o(tls_b_limit_o),
    .tls_b_attr_o(tls_b_attr_o), .frame_wr(frame_wr)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      err_count++;
      tally_and_finish();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic issue(input logic u, input logic [5:0] l);
    @(posedge clk);
    req <= 1'b1;
    user_enclave_op <= u;
    leaf <= l;
    @(posedge clk);
    req <= 1'b0;
    // results registered at the previous edge still stand here
    @(posedge clk);
  endtask : issue

  // 0 segment change, 1 tls base write a, 2 async exit, 3 tls base write b
  task automatic ev(input int k);
    @(posedge clk);
    seg_modify <= (k == 0);
    write_tls_base_a <= (k == 1);
    async_enclave_exit <= (k == 2);
    write_tls_base_b <= (k == 3);
    @(posedge clk);
    {seg_modify, write_tls_base_a, write_tls_base_b, async_enclave_exit} <= 4'h0;
    @(posedge clk);
  endtask : ev

  task automatic t_regs;
    bus(0, encl_chk_pkg::OFS_FEAT_CTRL, 32'h0);
    chk("feat_ctrl reset", q, encl_chk_pkg::FC_RESET);
    bus(0, encl_chk_pkg::OFS_CAPS, 32'h0);
    chk("caps gen1", q[encl_chk_pkg::CAPS_GEN1], 1);
    bus(0, 5'h1C, 32'h0);
    chk("unmapped", q, 0);
    bus(1, encl_chk_pkg::OFS_KEY_HASH, 32'hA5A5_5A5A);
    bus(0, encl_chk_pkg::OFS_KEY_HASH, 32'h0);
    chk("key hash unlocked", q, encl_chk_pkg::KEY_RESET);
    issue(1, encl_chk_pkg::LEAF_ENTRY);
    chk("fault disabled", fault, encl_chk_pkg::FLT_UD);
    bus(1, encl_chk_pkg::OFS_FEAT_CTRL, 32'h0004_0000);
    issue(1, encl_chk_pkg::LEAF_ENTRY);
    chk("fault not locked", fault, encl_chk_pkg::FLT_UD);
    bus(1, encl_chk_pkg::OFS_FEAT_CTRL, encl_chk_pkg::FC_WR_MASK);
    bus(1, encl_chk_pkg::OFS_FEAT_CTRL, 32'h0);
    bus(0, encl_chk_pkg::OFS_FEAT_CTRL, 32'h0);
    chk("feat_ctrl locked", q, encl_chk_pkg::FC_WR_MASK);
    bus(1, encl_chk_pkg::OFS_KEY_HASH, 32'hA5A5_5A5A);
    bus(0, encl_chk_pkg::OFS_KEY_HASH, 32'h0);
    chk("key hash locked", q, 32'hA5A5_5A5A);
    bus(0, encl_chk_pkg::OFS_STATUS, 32'h0);
    chk("status", q, 32'h0000_0019);
    bus(0, encl_chk_pkg::OFS_CAPS, 32'h0);
    chk("caps enable bit", q[encl_chk_pkg::FC_ENCL_EN], 0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_modes;
    encl_chk_pkg::fault_t exp [9];
    exp = '{encl_chk_pkg::FLT_UD, encl_chk_pkg::FLT_UD, encl_chk_pkg::FLT_UD, encl_chk_pkg::FLT_UD,
      encl_chk_pkg::FLT_NONE, encl_chk_pkg::FLT_NONE, encl_chk_pkg::FLT_UD, encl_chk_pkg::FLT_GP,
      encl_chk_pkg::FLT_GP};
    privilege_level <= encl_chk_pkg::PL_SUPERVISOR;
    for (int i = 0; i < 9; i++) begin
      prot_mode <= (i != 0);
      system_mgmt_mode <= (i == 1);
      virtual_8086_mode <= (i == 2);
      paging_enable <= !(i inside {3, 4, 5});
      opsize_prefix <= (i == 6);
      page_cache_access_ok <= (i == 6);
      ds_usable <= (i != 7);
      ds_expand_up <= (i != 8);
      issue(0, (i == 4) ? encl_chk_pkg::LEAF_DBG_RD : (i == 5) ? encl_chk_pkg::LEAF_DBG_WR : 6'h01);
      chk("mode fault", fault, exp[i]);
      chk("ad_set", ad_set, i == 6);
    end
    {prot_mode, paging_enable, ds_usable, ds_expand_up} <= 4'hF;
    {opsize_prefix, page_cache_access_ok} <= 2'h0;
    long_mode <= 1'b0;
    issue(0, 6'h01);
    chk("addr_64 legacy", addr_64, 0);
    long_mode <= 1'b1;
    cs_64bit <= 1'b0;
    issue(0, 6'h01);
    chk("addr_64 compat", addr_64, 0);
    cs_64bit <= 1'b1;
    issue(0, 6'h01);
    chk("addr_64 long", addr_64, 1);
    $display("test modes done");
  endtask : t_modes

  task automatic t_vm;
    guest_mode <= 1'b1;
    bus(1, encl_chk_pkg::OFS_BITMAP_LO, 32'h0000_0020);
    bus(1, encl_chk_pkg::OFS_BITMAP_HI, 32'h0000_0100);
    bus(0, encl_chk_pkg::OFS_BITMAP_HI, 32'h0);
    chk("bitmap hi", q, 32'h0000_0100);
    issue(0, 6'h05);
    chk("exiting off", fault, encl_chk_pkg::FLT_NONE);
    bus(1, encl_chk_pkg::OFS_EXIT_CTRL, 32'h0000_0001);
    issue(0, 6'h05);
    chk("bitmap low set", fault, encl_chk_pkg::FLT_VMEXIT);
    issue(0, 6'h06);
    chk("bitmap clear", fault, encl_chk_pkg::FLT_NONE);
    issue(0, 6'h28);
    chk("bitmap high set", fault, encl_chk_pkg::FLT_VMEXIT);
    privilege_level <= encl_chk_pkg::PL_USER;
    issue(0, 6'h05);
    chk("privilege before exit", fault, encl_chk_pkg::FLT_GP);
    issue(1, 6'h05);
    chk("user leaf in guest", fault, encl_chk_pkg::FLT_NONE);
    guest_mode <= 1'b0;
    $display("test vm done");
  endtask : t_vm

  task automatic t_enclave;
    privilege_level <= encl_chk_pkg::PL_SUPERVISOR;
    issue(1, encl_chk_pkg::LEAF_ENTRY);
    chk("entry privilege", fault == encl_chk_pkg::FLT_NONE, 0);
    chk("no entry", in_enclave, 0);
    privilege_level <= encl_chk_pkg::PL_USER;
    cs_64bit <= 1'b0;
    issue(1, encl_chk_pkg::LEAF_ENTRY);
    chk("entry code mode", fault == encl_chk_pkg::FLT_NONE, 0);
    cs_64bit <= 1'b1;
    other_bases_zero <= 1'b0;
    issue(1, encl_chk_pkg::LEAF_ENTRY);
    chk("entry bases", fault, encl_chk_pkg::FLT_GP);
    chk("no load on fault", tls_load, 0);
    other_bases_zero <= 1'b1;
    tls_a_limit <= 32'hFFFF_FFFF;
    issue(1, encl_chk_pkg::LEAF_ENTRY);
    chk("tls outside ds", fault, encl_chk_pkg::FLT_GP);
    tls_a_limit <= 32'h0000_00FF;
    issue(1, encl_chk_pkg::LEAF_ENTRY);
    chk("entry fault", fault, encl_chk_pkg::FLT_NONE);
    chk("entry load", tls_load, 1);
    chk("a base", tls_a_base_o, 64'h1100);
    chk("a limit", tls_a_limit_o, 32'hFF);
    chk("a attr", tls_a_attr_o, {16'h000B, 8'h93});
    chk("b base", tls_b_base_o, 64'h1200);
    chk("b limit", tls_b_limit_o, 32'hFF);
    chk("b attr", tls_b_attr_o, {16'h000B, 8'h93});
    chk("entered", in_enclave, 1);
    ev(0);
    chk("seg change done", done, 1);
    chk("seg change fault", fault, encl_chk_pkg::FLT_UD);
    ev(1);
    chk("tls write fault", fault, encl_chk_pkg::FLT_NONE);
    chk("tls write base", tls_a_base_o, 64'h1234);
    ev(3);
    chk("tls write b", tls_b_base_o, 64'h1234);
    ev(2);
    chk("frame write", frame_wr, 1);
    chk("aex restore a", tls_a_base_o, 64'hAAAA);
    chk("aex restore b", tls_b_base_o, 64'hBBBB);
    chk("aex left", in_enclave, 0);
    issue(1, encl_chk_pkg::LEAF_RESUME);
    chk("resume a", tls_a_base_o, 64'h1234);
    chk("resume b", tls_b_base_o, 64'h5678);
    issue(1, encl_chk_pkg::LEAF_EXIT);
    chk("exit load", tls_load, 1);
    chk("exit restore", tls_a_base_o, 64'hAAAA);
    chk("exit restore b", tls_b_base_o, 64'hBBBB);
    chk("exit a limit", tls_a_limit_o, 32'h0000_0FFF);
    chk("exit a attr", tls_a_attr_o, 24'h001193);
    chk("exit left", in_enclave, 0);
    ev(0);
    chk("ignored outside", done, 0);
    $display("test enclave done");
  endtask : t_enclave

  initial begin
    {avs_read, avs_write, system_mgmt_mode, virtual_8086_mode, guest_mode, req, user_enclave_op} = '0;
    {opsize_prefix, page_cache_access_ok, seg_modify, write_tls_base_a, write_tls_base_b, async_enclave_exit} = '0;
    {rst, prot_mode, paging_enable, long_mode, cs_64bit, ds_usable, ds_expand_up} = '1;
    {other_bases_zero, enclave_64bit_attr} = '1;
    {avs_address, leaf, avs_writedata, ds_base} = '0;
    privilege_level = encl_chk_pkg::PL_USER;
    avs_byteenable = 4'hF;
    ds_rights = 8'h93;
    ds_limit = 32'hFFFF_FFFF;
    {cur_a_limit, cur_b_limit} = {2{32'h0000_0FFF}};
    cur_a_attr = 24'h001193;
    cur_b_attr = 24'h002193;
    cur_a_base = 64'hAAAA;
    cur_b_base = 64'hBBBB;
    enclave_base = 64'h1000;
    tls_a_base_offset = 64'h100;
    tls_b_base_offset = 64'h200;
    {tls_a_limit, tls_b_limit} = {2{32'h0000_00FF}};
    frame_a_base = 64'h1234;
    frame_b_base = 64'h5678;
    tls_wdata = 64'h1234;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_vm();
    t_enclave();
    tally_and_finish();
  end
endmodule : enclave_instr_permission_check_tb
`default_nettype wire
